// *** hdl/rdcl_pkg.sv ***
// constants, types and character helpers for the relay driver command latch
// assumes a single mclk domain and byte-wide ascii command characters
package rdcl_pkg;

   // =====================================================================
   // sizes
   localparam int LINES    = 80;
   localparam int DIGITS   = 20;
   localparam int CHAN_MAX = 79;

   // =====================================================================
   // command characters
   localparam logic [7:0] CH_INTR  = 8'h49;
   localparam logic [7:0] CH_LOAD  = 8'h4c;
   localparam logic [7:0] CH_OPEN  = 8'h4f;
   localparam logic [7:0] CH_ERR   = 8'h45;
   localparam logic [7:0] CH_TRIG  = 8'h54;
   localparam logic [7:0] CH_BOTH  = 8'h2a;
   localparam logic [7:0] CH_DIS   = 8'h44;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_LF    = 8'h0a;
   localparam logic [7:0] CH_CR    = 8'h0d;

   // =====================================================================
   // interrupt selection, bit 0 = on error, bit 1 = on trigger
   typedef logic [1:0] rdcl_isel_t;
   localparam rdcl_isel_t ISEL_OFF  = 2'h0;
   localparam rdcl_isel_t ISEL_ERR  = 2'h1;
   localparam rdcl_isel_t ISEL_TRIG = 2'h2;
   localparam rdcl_isel_t ISEL_BOTH = 2'h3;
   localparam int ISEL_ON_ERR  = 0;
   localparam int ISEL_ON_TRIG = 1;

   // =====================================================================
   // error codes
   typedef logic [3:0] rdcl_err_t;
   localparam rdcl_err_t ERR_NONE    = 4'h0;
   localparam rdcl_err_t ERR_INTCMD  = 4'h1;
   localparam rdcl_err_t ERR_HEX     = 4'h2;
   localparam rdcl_err_t ERR_COUNT   = 4'h3;
   localparam rdcl_err_t ERR_CHAN    = 4'h4;
   localparam rdcl_err_t ERR_UNKNOWN = 4'h5;

   // =====================================================================
   // parser states
   typedef enum logic [5:0] {
      PS_IDLE = 6'b000001,
      PS_ISEL = 6'b000010,
      PS_IEND = 6'b000100,
      PS_LOAD = 6'b001000,
      PS_OPEN = 6'b010000,
      PS_SKIP = 6'b100000
   } rdcl_pstate_t;

   // =====================================================================
   // register map, byte addresses
   localparam logic [7:0] ADR_CMD    = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_CTRL   = 8'h08;
   localparam logic [7:0] ADR_ISTAT  = 8'h0c;
   localparam logic [7:0] ADR_IMASK  = 8'h10;
   localparam logic [7:0] ADR_OUT0   = 8'h14;
   localparam logic [7:0] ADR_OUT1   = 8'h18;
   localparam logic [7:0] ADR_OUT2   = 8'h1c;

   // status fields
   localparam int ST_ERRLED = 0;
   localparam int ST_PEND   = 1;
   localparam int ST_ISEL   = 2;
   localparam int ST_TRGMON = 4;
   localparam int ST_OUTEN  = 5;
   localparam int ST_REQ    = 6;
   localparam int ST_CODE   = 8;

   // control fields
   localparam int CTRL_TRGMON = 0;
   localparam int CTRL_OUTEN  = 1;
   localparam int CTRL_ERRCLR = 2;

   // interrupt status / mask fields
   localparam int IRQ_W    = 3;
   localparam int IRQ_ERR  = 0;
   localparam int IRQ_TRIG = 1;
   localparam int IRQ_REQ  = 2;

   // reset values
   localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

   // =====================================================================
   // character helpers
   function automatic logic isDec(input logic [7:0] c);
      return (c >= 8'h30) && (c <= 8'h39);
   endfunction

   function automatic logic isHex(input logic [7:0] c);
      return isDec(c) || ((c >= 8'h41) && (c <= 8'h46)) || ((c >= 8'h61) && (c <= 8'h66));
   endfunction

   function automatic logic [3:0] hexVal(input logic [7:0] c);
      logic [7:0] v;
      v = 8'h00;
      if (isDec(c)) begin
         v = c - 8'h30;
      end else if (c >= 8'h61) begin
         v = c - 8'h57;
      end else begin
         v = c - 8'h37;
      end
      return v[3:0];
   endfunction

   function automatic logic isTerm(input logic [7:0] c);
      return (c == CH_LF) || (c == CH_CR);
   endfunction

endpackage

// *** hdl/rdcl_cmd_if.sv ***
// carrier between the register side and the command parser
// assumes both ends run on the same mclk
`timescale 1ns/10ps
interface rdcl_cmd_if;
   import rdcl_pkg::*;
   logic             charValid;
   logic [7:0]       charData;
   logic             evIntSel;
   rdcl_isel_t       intSel;
   logic             evLoad;
   logic [LINES-1:0] loadImg;
   logic             evOpen;
   logic [6:0]       openChan;
   logic             evErr;
   rdcl_err_t        errCode;

   modport parser (
      input  charValid,
      input  charData,
      output evIntSel,
      output intSel,
      output evLoad,
      output loadImg,
      output evOpen,
      output openChan,
      output evErr,
      output errCode
   );
   modport latch (
      output charValid,
      output charData,
      input  evIntSel,
      input  intSel,
      input  evLoad,
      input  loadImg,
      input  evOpen,
      input  openChan,
      input  evErr,
      input  errCode
   );
endinterface

// *** hdl/rdcl_parser.sv ***
// ascii command parser: one character per cycle, results as one-cycle pulses
// assumes characters arrive from same-clock logic and are never stalled
`timescale 1ns/10ps
module rdcl_parser
   import rdcl_pkg::*;
(
   input wire logic  mclk,
   input wire logic  rst,
   rdcl_cmd_if.parser cif
);

   // =====================================================================
   // state
   rdcl_pstate_t     state_r, state_nxt;
   logic [4:0]       cnt_r, cnt_nxt;
   logic [LINES-1:0] img_r, img_nxt;
   logic [6:0]       acc_r, acc_nxt;
   logic             ovf_r, ovf_nxt;
   rdcl_isel_t       sel_r, sel_nxt;
   logic             evIntSel_r, evIntSel_nxt;
   logic             evLoad_r, evLoad_nxt;
   logic             evOpen_r, evOpen_nxt;
   logic             evErr_r, evErr_nxt;
   rdcl_err_t        code_r, code_nxt;

   // =====================================================================
   // next state
   always_comb begin
      logic [7:0]  c;
      logic [10:0] wide;
      c            = cif.charData;
      wide         = 11'h000;
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      img_nxt      = img_r;
      acc_nxt      = acc_r;
      ovf_nxt      = ovf_r;
      sel_nxt      = sel_r;
      evIntSel_nxt = 1'b0;
      evLoad_nxt   = 1'b0;
      evOpen_nxt   = 1'b0;
      evErr_nxt    = 1'b0;
      code_nxt     = code_r;
      if (cif.charValid) begin
         case (state_r)
            PS_IDLE: begin
               if (c == CH_INTR) begin
                  state_nxt = PS_ISEL;
               end else if (c == CH_LOAD) begin
                  state_nxt = PS_LOAD;
                  cnt_nxt   = 5'h00;
                  img_nxt   = '0;
               end else if (c == CH_OPEN) begin
                  state_nxt = PS_OPEN;
                  cnt_nxt   = 5'h00;
                  acc_nxt   = 7'h00;
                  ovf_nxt   = 1'b0;
               end else if (!isTerm(c) && c != CH_SPACE) begin
                  evErr_nxt = 1'b1;
                  code_nxt  = ERR_UNKNOWN;
                  state_nxt = PS_SKIP;
               end
            end
            PS_ISEL: begin
               if (c == CH_ERR) begin
                  sel_nxt   = ISEL_ERR;
                  state_nxt = PS_IEND;
               end else if (c == CH_TRIG) begin
                  sel_nxt   = ISEL_TRIG;
                  state_nxt = PS_IEND;
               end else if (c == CH_BOTH) begin
                  sel_nxt   = ISEL_BOTH;
                  state_nxt = PS_IEND;
               end else if (c == CH_DIS) begin
                  sel_nxt   = ISEL_OFF;
                  state_nxt = PS_IEND;
               end else if (c != CH_SPACE) begin
                  evErr_nxt = 1'b1;
                  code_nxt  = ERR_INTCMD;
                  state_nxt = isTerm(c) ? PS_IDLE : PS_SKIP;
               end
            end
            PS_IEND: begin
               if (isTerm(c)) begin
                  evIntSel_nxt = 1'b1;
                  state_nxt    = PS_IDLE;
               end else if (c != CH_SPACE) begin
                  evErr_nxt = 1'b1;
                  code_nxt  = ERR_INTCMD;
                  state_nxt = PS_SKIP;
               end
            end
            PS_LOAD: begin
               if (isTerm(c)) begin
                  state_nxt = PS_IDLE;
                  if (cnt_r == 5'h00) begin
                     evErr_nxt = 1'b1;
                     code_nxt  = ERR_HEX;
                  end else if (cnt_r != 5'(DIGITS)) begin
                     evErr_nxt = 1'b1;
                     code_nxt  = ERR_COUNT;
                  end else begin
                     evLoad_nxt = 1'b1;
                  end
               end else if (isHex(c)) begin
                  if (cnt_r == 5'(DIGITS)) begin
                     evErr_nxt = 1'b1;
                     code_nxt  = ERR_COUNT;
                     state_nxt = PS_SKIP;
                  end else begin
                     // first digit ends up in the top nibble
                     img_nxt = {img_r[LINES-5:0], hexVal(c)};
                     cnt_nxt = cnt_r + 5'h01;
                  end
               end else if (c != CH_SPACE) begin
                  evErr_nxt = 1'b1;
                  code_nxt  = ERR_HEX;
                  state_nxt = PS_SKIP;
               end
            end
            PS_OPEN: begin
               if (isTerm(c)) begin
                  state_nxt = PS_IDLE;
                  if (cnt_r == 5'h00 || ovf_r) begin
                     evErr_nxt = 1'b1;
                     code_nxt  = ERR_CHAN;
                  end else begin
                     evOpen_nxt = 1'b1;
                  end
               end else if (isDec(c)) begin
                  // set a sticky overflow flag and hold the accumulator so long numbers cannot wrap back into range
                  wide    = 11'(acc_r) * 11'd10 + 11'(hexVal(c));
                  cnt_nxt = (cnt_r == 5'h1f) ? cnt_r : cnt_r + 5'h01;
                  if (ovf_r || wide > 11'(CHAN_MAX)) begin
                     ovf_nxt = 1'b1;
                  end else begin
                     acc_nxt = wide[6:0];
                  end
               end else if (c != CH_SPACE) begin
                  evErr_nxt = 1'b1;
                  code_nxt  = ERR_CHAN;
                  state_nxt = PS_SKIP;
               end
            end
            PS_SKIP: begin
               if (isTerm(c)) begin
                  state_nxt = PS_IDLE;
               end
            end
            default: begin
               state_nxt = PS_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r    <= PS_IDLE;
         cnt_r      <= 5'h00;
         img_r      <= '0;
         acc_r      <= 7'h00;
         ovf_r      <= 1'b0;
         sel_r      <= ISEL_OFF;
         evIntSel_r <= 1'b0;
         evLoad_r   <= 1'b0;
         evOpen_r   <= 1'b0;
         evErr_r    <= 1'b0;
         code_r     <= ERR_NONE;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         img_r      <= img_nxt;
         acc_r      <= acc_nxt;
         ovf_r      <= ovf_nxt;
         sel_r      <= sel_nxt;
         evIntSel_r <= evIntSel_nxt;
         evLoad_r   <= evLoad_nxt;
         evOpen_r   <= evOpen_nxt;
         evErr_r    <= evErr_nxt;
         code_r     <= code_nxt;
      end
   end

   assign cif.evIntSel = evIntSel_r;
   assign cif.intSel   = sel_r;
   assign cif.evLoad   = evLoad_r;
   assign cif.loadImg  = img_r;
   assign cif.evOpen   = evOpen_r;
   assign cif.openChan = acc_r;
   assign cif.evErr    = evErr_r;
   assign cif.errCode  = code_r;

endmodule

// *** hdl/rdcl_top.sv ***
// relay driver command latch: wishbone registers, output image, trigger deferral, interrupts
// assumes a classic wishbone master on mclk and an asynchronous external trigger pin
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module rdcl_top
   import rdcl_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             extTrig,
   output logic      [LINES-1:0] relayOut,
   output logic                  errorLed,
   output logic                  irq
);

   // =====================================================================
   // parser
   rdcl_cmd_if cif ();

   rdcl_parser u_parser (
      .mclk (mclk),
      .rst  (rst),
      .cif  (cif)
   );

   // =====================================================================
   // state
   logic             ack_r, ack_nxt;
   logic [31:0]      dat_r, dat_nxt;
   rdcl_isel_t       isel_r, isel_nxt;
   logic             trgMon_r, trgMon_nxt;
   logic             outEn_r, outEn_nxt;
   logic             errLed_r, errLed_nxt;
   rdcl_err_t        code_r, code_nxt;
   logic [IRQ_W-1:0] iStat_r, iStat_nxt;
   logic [IRQ_W-1:0] iMask_r, iMask_nxt;
   logic [LINES-1:0] image_r, image_nxt;
   logic             pendLoad_r, pendLoad_nxt;
   logic [LINES-1:0] pendImg_r, pendImg_nxt;
   logic [LINES-1:0] pendOpen_r, pendOpen_nxt;
   logic [LINES-1:0] relay_r, relay_nxt;
   logic             irq_r, irq_nxt;
   logic             sync1_r, sync2_r, sync3_r;

   logic             busTake;
   logic             busWr;
   logic             wrLow;
   logic             trigRise;

   // =====================================================================
   // bus decode
   assign busTake       = wb_cyc_i && wb_stb_i && !ack_r;
   assign busWr         = busTake && wb_we_i;
   assign wrLow         = busWr && wb_sel_i[0];
   // each character write feeds the parser; it never stalls so no handshake is needed
   assign cif.charValid = wrLow && (wb_adr_i == ADR_CMD);
   assign cif.charData  = wb_dat_i[7:0];

   // only the third stage feeds the edge detect together with the second
   assign trigRise = sync2_r && !sync3_r;

   // =====================================================================
   // next state
   always_comb begin
      logic [LINES-1:0] openBit;
      logic [IRQ_W-1:0] iSet;
      logic [IRQ_W-1:0] iClr;
      logic             pendAny;
      openBit      = '0;
      iSet         = '0;
      iClr         = '0;
      pendAny      = pendLoad_r || (pendOpen_r != '0);
      ack_nxt      = busTake;
      dat_nxt      = 32'h0000_0000;
      isel_nxt     = isel_r;
      trgMon_nxt   = trgMon_r;
      outEn_nxt    = outEn_r;
      errLed_nxt   = errLed_r;
      code_nxt     = code_r;
      image_nxt    = image_r;
      pendLoad_nxt = pendLoad_r;
      pendImg_nxt  = pendImg_r;
      pendOpen_nxt = pendOpen_r;

      // register writes
      if (wrLow && wb_adr_i == ADR_CTRL) begin
         trgMon_nxt = wb_dat_i[CTRL_TRGMON];
         outEn_nxt  = wb_dat_i[CTRL_OUTEN];
         if (wb_dat_i[CTRL_ERRCLR]) begin
            errLed_nxt = 1'b0;
            code_nxt   = ERR_NONE;
         end
      end
      if (wrLow && wb_adr_i == ADR_ISTAT) begin
         iClr = wb_dat_i[IRQ_W-1:0];
      end
      iMask_nxt = (wrLow && wb_adr_i == ADR_IMASK) ? wb_dat_i[IRQ_W-1:0] : iMask_r;

      // pending work is released by the trigger, or at once if monitoring is switched off
      if (pendAny && ((trgMon_r && trigRise) || !trgMon_r)) begin
         if (pendLoad_r) begin
            image_nxt = pendImg_r & ~pendOpen_r;
         end else begin
            image_nxt = image_r & ~pendOpen_r;
         end
         pendLoad_nxt = 1'b0;
         pendOpen_nxt = '0;
      end
      if (trgMon_r && trigRise) begin
         iSet[IRQ_TRIG] = 1'b1;
         if (isel_r[ISEL_ON_TRIG]) begin
            iSet[IRQ_REQ] = 1'b1;
         end
      end

      // commands from the parser
      if (cif.evLoad) begin
         if (trgMon_r) begin
            pendLoad_nxt = 1'b1;
            pendImg_nxt  = cif.loadImg;
            pendOpen_nxt = '0;
         end else begin
            image_nxt = cif.loadImg;
         end
      end
      if (cif.evOpen) begin
         openBit[cif.openChan] = 1'b1;
         if (trgMon_r) begin
            pendOpen_nxt = pendOpen_nxt | openBit;
         end else begin
            image_nxt = image_nxt & ~openBit;
         end
      end
      if (cif.evIntSel) begin
         isel_nxt = cif.intSel;
         if (cif.intSel[ISEL_ON_ERR] && errLed_r) begin
            iSet[IRQ_REQ] = 1'b1;
         end
      end
      if (cif.evErr) begin
         errLed_nxt     = 1'b1;
         code_nxt       = cif.errCode;
         iSet[IRQ_ERR]  = 1'b1;
         if (isel_r[ISEL_ON_ERR]) begin
            iSet[IRQ_REQ] = 1'b1;
         end
      end

      // set wins over a clear in the same cycle
      iStat_nxt = (iStat_r & ~iClr) | iSet;

      // outputs follow the held image only once software has enabled them
      relay_nxt = image_nxt & {LINES{outEn_nxt}};
      irq_nxt   = |(iStat_nxt & iMask_nxt);

      // register reads
      if (busTake && !wb_we_i) begin
         case (wb_adr_i)
            ADR_STATUS: begin
               dat_nxt[ST_ERRLED]           = errLed_r;
               dat_nxt[ST_PEND]             = pendAny;
               dat_nxt[ST_ISEL+1:ST_ISEL]   = isel_r;
               dat_nxt[ST_TRGMON]           = trgMon_r;
               dat_nxt[ST_OUTEN]            = outEn_r;
               dat_nxt[ST_REQ]              = iStat_r[IRQ_REQ];
               dat_nxt[ST_CODE+3:ST_CODE]   = code_r;
            end
            ADR_CTRL: begin
               dat_nxt[CTRL_TRGMON] = trgMon_r;
               dat_nxt[CTRL_OUTEN]  = outEn_r;
            end
            ADR_ISTAT: begin
               dat_nxt[IRQ_W-1:0] = iStat_r;
            end
            ADR_IMASK: begin
               dat_nxt[IRQ_W-1:0] = iMask_r;
            end
            ADR_OUT0: begin
               dat_nxt = image_r[31:0];
            end
            ADR_OUT1: begin
               dat_nxt = image_r[63:32];
            end
            ADR_OUT2: begin
               dat_nxt[LINES-65:0] = image_r[LINES-1:64];
            end
            default: begin
               dat_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // =====================================================================
   // registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_r      <= 1'b0;
         dat_r      <= 32'h0000_0000;
         isel_r     <= ISEL_OFF;
         trgMon_r   <= 1'b0;
         outEn_r    <= 1'b0;
         errLed_r   <= 1'b0;
         code_r     <= ERR_NONE;
         iStat_r    <= '0;
         iMask_r    <= IMASK_RST;
         image_r    <= '0;
         pendLoad_r <= 1'b0;
         pendImg_r  <= '0;
         pendOpen_r <= '0;
         relay_r    <= '0;
         irq_r      <= 1'b0;
         sync1_r    <= 1'b0;
         sync2_r    <= 1'b0;
         sync3_r    <= 1'b0;
      end else begin
         ack_r      <= ack_nxt;
         dat_r      <= dat_nxt;
         isel_r     <= isel_nxt;
         trgMon_r   <= trgMon_nxt;
         outEn_r    <= outEn_nxt;
         errLed_r   <= errLed_nxt;
         code_r     <= code_nxt;
         iStat_r    <= iStat_nxt;
         iMask_r    <= iMask_nxt;
         image_r    <= image_nxt;
         pendLoad_r <= pendLoad_nxt;
         pendImg_r  <= pendImg_nxt;
         pendOpen_r <= pendOpen_nxt;
         relay_r    <= relay_nxt;
         irq_r      <= irq_nxt;
         sync1_r    <= extTrig;
         sync2_r    <= sync1_r;
         sync3_r    <= sync2_r;
      end
   end

   // =====================================================================
   // outputs
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign relayOut = relay_r;
   assign errorLed = errLed_r;
   assign irq      = irq_r;

endmodule

// *** verif/rdcl_checker.sv ***
// checker: bus handshake and indicator relations at the top ports
// assumes it is bound onto rdcl_top
`timescale 1ns/10ps
module rdcl_checker
   import rdcl_pkg::*;
(
   input wire logic             mclk,
   input wire logic             rst,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [7:0]       wb_adr_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic [LINES-1:0] relayOut,
   input wire logic             errorLed,
   input wire logic             irq
);
   // ===
   // properties
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic wr;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
   logic cmdWr;
   assign cmdWr = wr && (wb_adr_i == ADR_CMD);
   sequence sReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   AST_ACK_LAT: assert property (sReq |=> wb_ack_o) else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
   AST_RST_CLR: assert property ($fell(rst) |-> !irq && !errorLed && relayOut == '0)
      else $error("reset state");
   AST_LED_CAUSE: assert property ($rose(errorLed) |-> $past(cmdWr, 2))
      else $error("led without command");
   // clearing needs a bus write one or two cycles before, never by itself
   AST_LED_HOLD: assert property ($fell(errorLed) |-> $past(wr) || $past(wr, 2))
      else $error("led dropped");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
      else $error("irq dropped");
endmodule
bind rdcl_top rdcl_checker rdcl_checker_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .relayOut(relayOut), .errorLed(errorLed), .irq(irq));

// *** verif/rdcl_host.sv ***
// wishbone host model that sends the command characters
// assumes tasks are entered right after a rising mclk edge
`timescale 1ns/10ps
module rdcl_host
(
   input  wire logic        mclk,
   input  wire logic        ack,
   input  wire logic [31:0] datI,
   output logic             cyc = 1'b0,
   output logic             we = 1'b0,
   output logic [7:0]       adr = 8'h00,
   output logic [31:0]      datO = 32'h0,
   output logic             hung = 1'b0
);
   // request held until ack is seen; a dead slave ends the run
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      datO <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      hung <= (n >= 50);
      q = datI;
      cyc <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

// *** verif/rdcl_top_tb.sv ***
// self-checking bench for the relay driver command latch
// assumes rdcl_host drives the bus and the checker is bound
`timescale 1ns/10ps
module rdcl_top_tb;
   import rdcl_pkg::*;
   typedef struct {string c; logic [3:0] e; logic [1:0] s; logic [79:0] m;} rdcl_row_t;
   localparam logic [79:0] IMG = 80'h7f00550000ffff55a801;
   logic mclk = 1'b0, rst = 1'b1, extTrig = 1'b0, ack, cyc, we, irq, errorLed, hung;
   logic [7:0] adr;
   logic [31:0] datO, datI, q;
   logic [79:0] relayOut;
   int n_fail = 0, n_checks = 0, k;
   rdcl_row_t rows[11] = '{'{"IE", 4'h0, 2'h1, 80'h0}, '{"IT", 4'h0, 2'h2, 80'h0},
      '{"I*", 4'h0, 2'h3, 80'h0}, '{"ID", 4'h0, 2'h0, 80'h0}, '{"IX", 4'h1, 2'h0, 80'h0},
      '{"Lff00550000ffff55aa01", 4'h0, 2'h0, 80'hff00550000ffff55aa01},
      '{"O 9", 4'h0, 2'h0, 80'hff00550000ffff55a801}, '{"O79", 4'h0, 2'h0, IMG},
      '{"O80", 4'h4, 2'h0, IMG}, '{"L12", 4'h3, 2'h0, IMG},
      '{"Lff00550000ffff55aa0g", 4'h2, 2'h0, IMG}};
   always #2 mclk = ~mclk;
   rdcl_top rdcl_top_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(datO), .wb_dat_o(datI), .wb_ack_o(ack),
      .extTrig(extTrig), .relayOut(relayOut), .errorLed(errorLed), .irq(irq));
   rdcl_host rdcl_host_inst (.mclk(mclk), .ack(ack), .datI(datI), .cyc(cyc), .we(we), .adr(adr),
      .datO(datO), .hung(hung));
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // terminator appended; two edges let image and status settle
   task automatic send(input string s);
      for (int i = 0; i <= s.len(); i++) begin
         rdcl_host_inst.xfer(1'b1, ADR_CMD, (i < s.len()) ? 32'(s[i]) : 32'(CH_LF), q);
      end
      repeat (2) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      rdcl_host_inst.xfer(1'b1, a, d, q);
   endtask
   always @(posedge hung) begin
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdcl_host_inst.xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         wr(ADR_CTRL, 32'h6);
         send(rows[i].c);
         rdcl_host_inst.xfer(1'b0, ADR_STATUS, 32'h0, q);
         chk({q[11:8], q[3:2]}, {rows[i].e, rows[i].s});
         chk(relayOut, rows[i].m);
      end
      wr(ADR_IMASK, 32'h4);
      send("O99");
      chk({irq, errorLed}, 2'b01);
      send("IE");
      chk(irq, 1'b1);
      wr(ADR_ISTAT, 32'h7);
      send("Q");
      rdcl_host_inst.xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk({irq, q[6]}, 2'b11);
      rdcl_host_inst.xfer(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      wr(ADR_CTRL, 32'h3);
      send("L00000000000000000fff");
      send("O0");
      // switch to trigger interrupts and start from a clean event register
      send("IT");
      wr(ADR_ISTAT, 32'h7);
      chk(relayOut, IMG);
      extTrig <= 1'b1;
      k = 0;
      while (relayOut === IMG && k < 20) begin
         @(posedge mclk);
         k++;
      end
      @(posedge mclk);
      chk(relayOut, 80'hffe);
      rdcl_host_inst.xfer(1'b0, ADR_ISTAT, 32'h0, q);
      chk({irq, q}, {1'b1, 32'h6});
      // reset in mid-run must drop selection, enable and image again
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdcl_host_inst.xfer(1'b0, ADR_STATUS, 32'h0, q);
      chk(q, 32'h0);
      chk(relayOut, 80'h0);
      finish_test();
   end
endmodule
